// ==== ubdie_pkg.sv ====
// Package with register map, field layout, reset values and carrier types of the UART divisor block
package ubdie_pkg;

	// Byte addresses of the register port
	localparam logic [31:0] UBDIE_BASE_ADDR       = 32'h4000_8000;
	localparam logic [31:0] UBDIE_DIV_LOW_ADDR    = 32'h4000_8000;
	localparam logic [31:0] UBDIE_DIV_HIGH_ADDR   = 32'h4000_8004;
	localparam logic [31:0] UBDIE_IRQ_ENABLE_ADDR = 32'h4000_8004;
	localparam logic [31:0] UBDIE_LINE_CTRL_ADDR  = 32'h4000_800C;
	localparam logic [31:0] UBDIE_LINE_STAT_ADDR  = 32'h4000_8014;
	localparam logic [31:0] UBDIE_FRAC_DIV_ADDR   = 32'h4000_8028;
	localparam logic [31:0] UBDIE_IRQ_STAT_ADDR   = 32'h4000_8060;
	localparam logic [31:0] UBDIE_IRQ_MASK_ADDR   = 32'h4000_8064;

	// Reset values
	localparam logic [7:0]  UBDIE_DIV_LOW_RESET   = 8'h01;
	localparam logic [7:0]  UBDIE_DIV_HIGH_RESET  = 8'h00;
	localparam logic [9:0]  UBDIE_IRQ_EN_RESET    = 10'h000;
	localparam logic [7:0]  UBDIE_LINE_CTRL_RESET = 8'h00;
	localparam logic [7:0]  UBDIE_FRAC_DIV_RESET  = 8'h10;
	localparam logic [4:0]  UBDIE_EVENT_RESET     = 5'h00;

	// Field positions
	localparam int UBDIE_ACCESS_SELECT_BIT = 7;
	localparam int UBDIE_EN_RX_DATA_BIT    = 0;
	localparam int UBDIE_EN_TX_EMPTY_BIT   = 1;
	localparam int UBDIE_EN_RX_LINE_BIT    = 2;
	localparam int UBDIE_EN_AB_DONE_BIT    = 8;
	localparam int UBDIE_EN_AB_TIMEOUT_BIT = 9;
	localparam int UBDIE_LSR_TX_EMPTY_BIT  = 5;
	localparam int UBDIE_LSR_ERR_LO_BIT    = 1;
	localparam int UBDIE_LSR_ERR_HI_BIT    = 4;
	localparam int UBDIE_SOURCE_COUNT      = 5;

	// Writable enable bits; reserved bits never store
	localparam logic [9:0]  UBDIE_IRQ_EN_WMASK    = 10'h307;
	localparam logic [15:0] UBDIE_DIV_ONE         = 16'h0001;
	localparam logic [15:0] UBDIE_DIV_ZERO        = 16'h0000;

	// Raw conditions coming from the rest of the UART
	typedef struct packed {
		logic       autobaud_timeout;
		logic       autobaud_done_flag;
		logic [3:0] rx_line_errors;
		logic       tx_holding_empty;
		logic       char_timeout_indication;
		logic       rx_data_available;
	} ubdie_raw_type;

	// Enabled sources presented to priority logic
	typedef struct packed {
		logic autobaud_timeout;
		logic autobaud_done;
		logic rx_line;
		logic tx_empty;
		logic char_timeout;
		logic rx_data;
	} ubdie_src_type;

	// Register port request
	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} ubdie_bus_req_type;

endpackage

// ==== ubdie_frac_stage.sv ====
// Fractional pre-divider that thins the peripheral clock into enable pulses
`timescale 1ns/1ps
module ubdie_frac_stage
	import ubdie_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic [7:0] frac_i,
	output logic            tick_o
);

	typedef struct packed {
		logic [4:0] acc;
		logic       tick;
	} ubdie_frac_state_type;

	ubdie_frac_state_type state_reg;
	ubdie_frac_state_type state_next;
	logic [3:0]           add_val;
	logic [3:0]           mul_val;
	logic [4:0]           sum;

	// Pass ratio mul/(mul+add); add of zero or not below mul passes every edge
	always_comb begin
		add_val = frac_i[3:0];
		mul_val = (frac_i[7:4] == 4'h0) ? 4'h1 : frac_i[7:4];
		state_next = state_reg;
		sum = state_reg.acc + 5'(add_val);
		if (add_val == 4'h0 || add_val >= mul_val) begin
			state_next.tick = 1'b1;
			state_next.acc  = 5'h00;
		end else if (state_reg.acc >= 5'(mul_val)) begin
			// A skipped edge only pays back one step; adding here would thin too much
			state_next.tick = 1'b0;
			state_next.acc  = state_reg.acc - 5'(mul_val);
		end else begin
			state_next.tick = 1'b1;
			state_next.acc  = sum;
		end
	end

	// State register
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign tick_o = state_reg.tick;

endmodule

// ==== ubdie_baud_counter.sv ====
// Baud divider counting fractional ticks up from zero to one below the divisor
`timescale 1ns/1ps
module ubdie_baud_counter
	import ubdie_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        tick_i,
	input  wire logic [15:0] divisor_i,
	output logic             baud16_o
);

	typedef struct packed {
		logic [15:0] count;
		logic        pulse;
	} ubdie_cnt_state_type;

	ubdie_cnt_state_type state_reg;
	ubdie_cnt_state_type state_next;
	logic [15:0]         eff_div;

	// One pulse per divisor ticks gives sixteen times the bit rate
	always_comb begin
		eff_div = (divisor_i == UBDIE_DIV_ZERO) ? UBDIE_DIV_ONE : divisor_i;
		state_next = state_reg;
		state_next.pulse = 1'b0;
		if (tick_i) begin
			if (state_reg.count + 16'h0001 >= eff_div) begin
				state_next.count = 16'h0000;
				state_next.pulse = 1'b1;
			end else begin
				state_next.count = state_reg.count + 16'h0001;
			end
		end
	end

	// State register
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign baud16_o = state_reg.pulse;

endmodule

// ==== ubdie_top.sv ====
// Divisor latch, interrupt source enable, register port and baud tick generation
`timescale 1ns/1ps
module ubdie_top
	import ubdie_pkg::*;
(
	input  wire logic                     clk_i,
	input  wire logic                     rst_i,
	input  wire logic [31:0]              addr_i,
	input  wire logic [31:0]              wdata_i,
	input  wire logic                     wr_i,
	input  wire logic                     rd_i,
	output logic [31:0]                   rdata_o,
	input  wire ubdie_pkg::ubdie_raw_type raw_i,
	input  wire logic [7:0]               rx_buffer_i,
	output logic                          rx_buffer_pop_o,
	output logic [7:0]                    tx_holding_o,
	output logic                          tx_holding_push_o,
	output logic                          divisor_access_select_o,
	output ubdie_pkg::ubdie_src_type      src_o,
	output logic                          autobaud_done_flag_o,
	output logic                          baud16_o,
	output logic                          irq_o
);
	import ubdie_pkg::*;

	// Whole register state of the block
	typedef struct packed {
		logic [7:0]  divisor_low_field;
		logic [7:0]  divisor_high_field;
		logic [9:0]  interrupt_source_enable;
		logic [7:0]  line_control_reg;
		logic [7:0]  frac_div;
		logic [4:0]  event_status;
		logic [4:0]  event_mask;
		logic [4:0]  src_prev;
		logic [31:0] rdata;
		logic [7:0]  tx_holding;
		logic        tx_push;
		logic        rx_pop;
	} ubdie_state_type;

	ubdie_state_type state_reg;
	ubdie_state_type state_next;
	ubdie_bus_req_type bus;
	ubdie_src_type     src;
	logic              divisor_access_select;
	logic [15:0]       divisor;
	logic [4:0]        src_vec;
	logic [4:0]        src_rise;
	logic              frac_tick;
	logic [7:0]        line_status;

	// Bundle the register port
	always_comb begin
		bus.addr  = addr_i;
		bus.wdata = wdata_i;
		bus.wr    = wr_i;
		bus.rd    = rd_i;
	end

	assign divisor_access_select = state_reg.line_control_reg[UBDIE_ACCESS_SELECT_BIT];
	assign divisor = {state_reg.divisor_high_field, state_reg.divisor_low_field};

	// Sources gated by their enables; disabled ones never request
	always_comb begin
		src.rx_data = raw_i.rx_data_available
			& state_reg.interrupt_source_enable[UBDIE_EN_RX_DATA_BIT];
		src.char_timeout = raw_i.char_timeout_indication
			& state_reg.interrupt_source_enable[UBDIE_EN_RX_DATA_BIT];
		src.tx_empty = raw_i.tx_holding_empty
			& state_reg.interrupt_source_enable[UBDIE_EN_TX_EMPTY_BIT];
		src.rx_line = (|raw_i.rx_line_errors)
			& state_reg.interrupt_source_enable[UBDIE_EN_RX_LINE_BIT];
		src.autobaud_done = raw_i.autobaud_done_flag
			& state_reg.interrupt_source_enable[UBDIE_EN_AB_DONE_BIT];
		src.autobaud_timeout = raw_i.autobaud_timeout
			& state_reg.interrupt_source_enable[UBDIE_EN_AB_TIMEOUT_BIT];
	end

	// Event vector for the sticky status register
	assign src_vec = {src.autobaud_timeout, src.autobaud_done, src.rx_line, src.tx_empty,
		src.rx_data | src.char_timeout};
	assign src_rise = src_vec & ~state_reg.src_prev;

	// Line status view built from the raw flags
	always_comb begin
		line_status = 8'h00;
		line_status[0] = raw_i.rx_data_available;
		line_status[UBDIE_LSR_ERR_HI_BIT:UBDIE_LSR_ERR_LO_BIT] = raw_i.rx_line_errors;
		line_status[UBDIE_LSR_TX_EMPTY_BIT] = raw_i.tx_holding_empty;
	end

	// Register access, decode and event capture
	always_comb begin
		state_next = state_reg;
		state_next.tx_push = 1'b0;
		state_next.rx_pop  = 1'b0;
		state_next.src_prev = src_vec;
		state_next.rdata = 32'h0000_0000;
		// Writes; the shared addresses follow the access select bit
		if (bus.wr) begin
			unique case (bus.addr)
				UBDIE_DIV_LOW_ADDR: begin
					if (divisor_access_select) begin
						state_next.divisor_low_field = bus.wdata[7:0];
					end else begin
						state_next.tx_holding = bus.wdata[7:0];
						state_next.tx_push    = 1'b1;
					end
				end
				UBDIE_DIV_HIGH_ADDR: begin
					if (divisor_access_select) begin
						state_next.divisor_high_field = bus.wdata[7:0];
					end else begin
						// Reserved bits are dropped so they read back as zero
						state_next.interrupt_source_enable =
							bus.wdata[9:0] & UBDIE_IRQ_EN_WMASK;
					end
				end
				UBDIE_LINE_CTRL_ADDR: state_next.line_control_reg = bus.wdata[7:0];
				UBDIE_FRAC_DIV_ADDR:  state_next.frac_div = bus.wdata[7:0];
				UBDIE_IRQ_MASK_ADDR:  state_next.event_mask = bus.wdata[4:0];
				default: ;
			endcase
		end
		// Reads; unmapped addresses answer zero
		if (bus.rd) begin
			unique case (bus.addr)
				UBDIE_DIV_LOW_ADDR: begin
					if (divisor_access_select) begin
						state_next.rdata = {24'h000000, state_reg.divisor_low_field};
					end else begin
						state_next.rdata  = {24'h000000, rx_buffer_i};
						state_next.rx_pop = 1'b1;
					end
				end
				UBDIE_DIV_HIGH_ADDR: begin
					if (divisor_access_select) begin
						state_next.rdata = {24'h000000, state_reg.divisor_high_field};
					end else begin
						state_next.rdata = {22'h0, state_reg.interrupt_source_enable};
					end
				end
				UBDIE_LINE_CTRL_ADDR: state_next.rdata = {24'h000000, state_reg.line_control_reg};
				UBDIE_LINE_STAT_ADDR: state_next.rdata = {24'h000000, line_status};
				UBDIE_FRAC_DIV_ADDR:  state_next.rdata = {24'h000000, state_reg.frac_div};
				UBDIE_IRQ_STAT_ADDR:  state_next.rdata = {27'h00, state_reg.event_status};
				UBDIE_IRQ_MASK_ADDR:  state_next.rdata = {27'h00, state_reg.event_mask};
				default: ;
			endcase
		end
		// Read clears the status; a new rising event in that cycle still sets
		if (bus.rd && bus.addr == UBDIE_IRQ_STAT_ADDR) begin
			state_next.event_status = src_rise;
		end else begin
			state_next.event_status = state_reg.event_status | src_rise;
		end
	end

	// State register with documented reset values
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_reg.divisor_low_field       <= UBDIE_DIV_LOW_RESET;
			state_reg.divisor_high_field      <= UBDIE_DIV_HIGH_RESET;
			state_reg.interrupt_source_enable <= UBDIE_IRQ_EN_RESET;
			state_reg.line_control_reg        <= UBDIE_LINE_CTRL_RESET;
			state_reg.frac_div                <= UBDIE_FRAC_DIV_RESET;
			state_reg.event_status            <= UBDIE_EVENT_RESET;
			state_reg.event_mask              <= UBDIE_EVENT_RESET;
			state_reg.src_prev                <= UBDIE_EVENT_RESET;
			state_reg.rdata                   <= 32'h0000_0000;
			state_reg.tx_holding              <= 8'h00;
			state_reg.tx_push                 <= 1'b0;
			state_reg.rx_pop                  <= 1'b0;
		end else begin
			state_reg <= state_next;
		end
	end

	// Fractional stage feeding the divisor counter
	ubdie_frac_stage u_frac (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.frac_i (state_reg.frac_div),
		.tick_o (frac_tick)
	);

	// Divisor counter producing the sixteen-times tick
	ubdie_baud_counter u_baud (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.tick_i    (frac_tick),
		.divisor_i (divisor),
		.baud16_o  (baud16_o)
	);

	// Outputs
	assign rdata_o                 = state_reg.rdata;
	assign tx_holding_o            = state_reg.tx_holding;
	assign tx_holding_push_o       = state_reg.tx_push;
	assign rx_buffer_pop_o         = state_reg.rx_pop;
	assign divisor_access_select_o = divisor_access_select;
	assign src_o                   = src;
	assign autobaud_done_flag_o    = src.autobaud_done;
	assign irq_o                   = |(state_reg.event_status & state_reg.event_mask);

endmodule

// ==== ubdie_bus_master.sv ====
// Behavioural processor bus master driving the register port
`timescale 1ns/1ps
module ubdie_bus_master (
	input  wire logic        clk_i,
	input  wire logic [31:0] rdata_i,
	output logic [31:0]      addr_o,
	output logic [31:0]      wdata_o,
	output logic             wr_o,
	output logic             rd_o
);
	// Idle bus from time zero
	initial begin
		addr_o = 32'h0000_0000;
		wdata_o = 32'h0000_0000;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end

	// One-cycle write; data inverted after release so stale values show
	task automatic write_reg(input logic [31:0] a, input logic [31:0] d);
		@(posedge clk_i);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= 1'b1;
		@(posedge clk_i);
		wr_o <= 1'b0;
		wdata_o <= ~d;
	endtask

	// One-cycle read; data taken only in the following cycle
	task automatic read_reg(input logic [31:0] a, output logic [31:0] d);
		@(posedge clk_i);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge clk_i);
		rd_o <= 1'b0;
		#1;
		d = rdata_i;
	endtask
endmodule

// ==== ubdie_checker_assertions.sv ====
// Concurrent checks on the register port and source gating
`timescale 1ns/1ps
module ubdie_checker
	import ubdie_pkg::*;
(
	input wire logic                     clk_i,
	input wire logic                     rst_i,
	input wire logic [31:0]              addr_i,
	input wire logic [31:0]              wdata_i,
	input wire logic                     wr_i,
	input wire logic                     rd_i,
	input wire logic [31:0]              rdata_o,
	input wire ubdie_pkg::ubdie_raw_type raw_i,
	input wire logic [7:0]               rx_buffer_i,
	input wire logic                     rx_buffer_pop_o,
	input wire logic [7:0]               tx_holding_o,
	input wire logic                     tx_holding_push_o,
	input wire logic                     divisor_access_select_o,
	input wire ubdie_pkg::ubdie_src_type src_o,
	input wire logic                     autobaud_done_flag_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// Base location decodes while the divisor is hidden
	wire base_rd = rd_i && addr_i == UBDIE_BASE_ADDR && !divisor_access_select_o;
	wire base_wr = wr_i && addr_i == UBDIE_BASE_ADDR && !divisor_access_select_o;

	// Enabling receive data, then a pending condition with no further write
	sequence rx_enable_set;
		wr_i && addr_i == UBDIE_IRQ_ENABLE_ADDR && !divisor_access_select_o && wdata_i[0];
	endsequence
	sequence rx_pending;
		!wr_i && raw_i.rx_data_available;
	endsequence

	rx_buffer_read_a: assert property (base_rd |=>
		rdata_o == {24'h000000, $past(rx_buffer_i)} && rx_buffer_pop_o) else $error("rx read bad");
	pop_cause_a: assert property (rx_buffer_pop_o |-> $past(base_rd))
		else $error("stray pop");
	tx_push_a: assert property (base_wr |=> tx_holding_push_o
		&& tx_holding_o == $past(wdata_i[7:0])) else $error("tx push bad");
	select_write_a: assert property (wr_i && addr_i == UBDIE_LINE_CTRL_ADDR |=>
		divisor_access_select_o == $past(wdata_i[7])) else $error("select bit bad");
	high_width_a: assert property (rd_i && divisor_access_select_o &&
		addr_i == UBDIE_DIV_HIGH_ADDR |=> rdata_o[31:8] == 24'h000000) else $error("high wide");
	shared_gate_a: assert property (raw_i.rx_data_available && raw_i.char_timeout_indication
		|-> src_o.rx_data == src_o.char_timeout) else $error("bit 0 split");
	rx_enable_a: assert property (rx_enable_set ##1 rx_pending |-> src_o.rx_data)
		else $error("rx not enabled");
	tx_gate_a: assert property (src_o.tx_empty |-> raw_i.tx_holding_empty)
		else $error("tx source false");
	line_gate_a: assert property (src_o.rx_line |-> (|raw_i.rx_line_errors))
		else $error("line source false");
	done_flag_a: assert property (autobaud_done_flag_o == src_o.autobaud_done
		&& (!src_o.autobaud_done || raw_i.autobaud_done_flag)) else $error("done flag bad");
	timeout_gate_a: assert property (src_o.autobaud_timeout |-> raw_i.autobaud_timeout)
		else $error("timeout source false");
endmodule

bind ubdie_top ubdie_checker ubdie_checker_inst (.clk_i(clk_i), .rst_i(rst_i),
	.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
	.raw_i(raw_i), .rx_buffer_i(rx_buffer_i), .rx_buffer_pop_o(rx_buffer_pop_o),
	.tx_holding_o(tx_holding_o), .tx_holding_push_o(tx_holding_push_o),
	.divisor_access_select_o(divisor_access_select_o), .src_o(src_o),
	.autobaud_done_flag_o(autobaud_done_flag_o));

// ==== test_uart_baud_divisor_and_irq_enable.sv ====
// Self-checking bench for the divisor latch and interrupt enable block
`timescale 1ns/1ps
module test_uart_baud_divisor_and_irq_enable;
	import ubdie_pkg::*;
	logic          clk_i = 1'b0;
	logic          rst_i = 1'b1;
	logic [31:0]   addr, wdata, rdata;
	logic          wr, rd, pop_o, push_o, sel_o, done_o, baud_o, irq_o;
	logic [7:0]    rx_byte = 8'h00;
	logic [7:0]    tx_o;
	ubdie_raw_type raw = '0;
	ubdie_src_type src_o;
	int            n_mismatch = 0;
	int            n_checks = 0;

	// Free-running clock
	always #5 clk_i = ~clk_i;

	ubdie_top ubdie_top_inst (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr), .wdata_i(wdata),
		.wr_i(wr), .rd_i(rd), .rdata_o(rdata), .raw_i(raw), .rx_buffer_i(rx_byte),
		.rx_buffer_pop_o(pop_o), .tx_holding_o(tx_o), .tx_holding_push_o(push_o),
		.divisor_access_select_o(sel_o), .src_o(src_o), .autobaud_done_flag_o(done_o),
		.baud16_o(baud_o), .irq_o(irq_o));
	ubdie_bus_master ubdie_bus_master_inst (.clk_i(clk_i), .rdata_i(rdata), .addr_o(addr),
		.wdata_o(wdata), .wr_o(wr), .rd_o(rd));

	// Count a comparison, report a mismatch at once
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic wreg(input logic [31:0] a, input logic [31:0] d);
		ubdie_bus_master_inst.write_reg(a, d);
	endtask

	task automatic rcheck(input logic [31:0] a, input logic [31:0] exp, input string what);
		logic [31:0] d;
		ubdie_bus_master_inst.read_reg(a, d);
		check(d, exp, what);
	endtask

	// Line control bit 7 steers the shared locations
	task automatic select(input logic s);
		wreg(UBDIE_LINE_CTRL_ADDR, {24'h000000, s, 7'h00});
	endtask

	// Cycles between two baud pulses; the first span flushes the old count
	task automatic set_div(input logic [15:0] d, output int p);
		wreg(UBDIE_DIV_LOW_ADDR, {24'h000000, d[7:0]});
		wreg(UBDIE_DIV_HIGH_ADDR, {24'h000000, d[15:8]});
		repeat (2) begin
			p = 0;
			do begin
				@(negedge clk_i);
				p++;
			end while (baud_o !== 1'b1 && p < 3000);
		end
	endtask

	task automatic test_reset;
		select(1'b1);
		rcheck(UBDIE_DIV_LOW_ADDR, 32'h01, "low reset");
		rcheck(UBDIE_DIV_HIGH_ADDR, 32'h00, "high reset");
		select(1'b0);
		rcheck(UBDIE_IRQ_ENABLE_ADDR, 32'h000, "enable reset");
	endtask

	// Only period differences are judged; the fixed offset is design latency
	task automatic test_divisor;
		int p1, p0, p5, pb, pf;
		select(1'b1);
		set_div(16'h0001, p1);
		set_div(16'h0000, p0);
		check(32'(p0), 32'(p1), "zero divisor");
		set_div(16'h0005, p5);
		check(32'(p5 - p1), 32'h4, "divisor 5");
		set_div(16'h0102, pb);
		check(32'(pb - p1), 32'h101, "divisor 258");
		rcheck(UBDIE_DIV_LOW_ADDR, 32'h02, "low byte");
		rcheck(UBDIE_DIV_HIGH_ADDR, 32'h01, "high byte");
		// Two of three edges pass, two ticks per pulse: a pulse every third cycle
		wreg(UBDIE_FRAC_DIV_ADDR, 32'h21);
		set_div(16'h0002, pf);
		check(32'(pf - p1), 32'h2, "fractional");
	endtask

	task automatic test_base;
		select(1'b0);
		@(posedge clk_i);
		rx_byte <= 8'h3C;
		rcheck(UBDIE_BASE_ADDR, 32'h3C, "rx buffer");
		check(32'(pop_o), 32'h1, "pop pulse");
		wreg(UBDIE_BASE_ADDR, 32'hA5);
		#1;
		check(32'({push_o, tx_o}), 32'h1A5, "tx push");
		select(1'b1);
		#1;
		check(32'(sel_o), 32'h1, "select level");
		rcheck(UBDIE_DIV_LOW_ADDR, 32'h02, "divisor kept");
	endtask

	// One enable at a time with every raw condition active
	task automatic test_enables;
		int         pos [5] = '{0, 1, 2, 8, 9};
		logic [6:0] exp [5] = '{7'h03, 7'h04, 7'h08, 7'h50, 7'h20};
		select(1'b0);
		@(posedge clk_i);
		raw <= '1;
		wreg(UBDIE_IRQ_ENABLE_ADDR, 32'h307);
		rcheck(UBDIE_IRQ_ENABLE_ADDR, 32'h307, "enable readback");
		rcheck(UBDIE_LINE_STAT_ADDR, 32'h3F, "line status");
		for (int k = 0; k < 5; k++) begin
			wreg(UBDIE_IRQ_ENABLE_ADDR, 32'h1 << pos[k]);
			#1;
			check(32'({done_o, src_o}), 32'(exp[k]), "gated source");
		end
		wreg(UBDIE_IRQ_ENABLE_ADDR, 32'h000);
		#1;
		check(32'({done_o, src_o}), 32'h00, "all disabled");
		@(posedge clk_i);
		raw <= '0;
	endtask

	task automatic test_irq;
		logic [31:0] d;
		ubdie_bus_master_inst.read_reg(UBDIE_IRQ_STAT_ADDR, d);
		wreg(UBDIE_IRQ_ENABLE_ADDR, 32'h001);
		wreg(UBDIE_IRQ_MASK_ADDR, 32'h01);
		@(posedge clk_i);
		raw.rx_data_available <= 1'b1;
		repeat (2) @(posedge clk_i);
		#1;
		check(32'(irq_o), 32'h1, "irq raised");
		rcheck(UBDIE_IRQ_STAT_ADDR, 32'h01, "status");
		@(posedge clk_i);
		#1;
		check(32'(irq_o), 32'h0, "irq cleared");
		wreg(UBDIE_IRQ_MASK_ADDR, 32'h00);
		raw.rx_data_available <= 1'b0;
		@(posedge clk_i);
		raw.rx_data_available <= 1'b1;
		repeat (2) @(posedge clk_i);
		#1;
		check(32'(irq_o), 32'h0, "irq masked");
		rcheck(UBDIE_IRQ_STAT_ADDR, 32'h01, "sticky status");
		rcheck(32'h4000_8040, 32'h0, "unmapped");
	endtask

	// Reset in mid-run must bring back the divisor, enable and fractional defaults over written values
	task automatic test_midreset;
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		test_reset();
		rcheck(UBDIE_FRAC_DIV_ADDR, 32'(UBDIE_FRAC_DIV_RESET), "frac reset");
	endtask

	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Main sequence after an eight-cycle reset
	initial begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		test_reset();
		test_divisor();
		test_base();
		test_enables();
		test_irq();
		test_midreset();
		complete_run();
	end

	// Watchdog well beyond the several hundred cycles the tests need
	initial begin
		#200000;
		n_mismatch++;
		complete_run();
	end
endmodule
